// *** hdl/gtps_slicer.sv ***
// Gear tooth peak and valley slicer: tracking, slicing, preload, lockout, startup
`timescale 1ns/100ps
`default_nettype none
`include "gtps_defines.svh"

module gtps_slicer #(
	parameter int SAMPLE_W    = `GTPS_SAMPLE_W,
	parameter int TRACK_CYCLES = `GTPS_TRACK_CYCLES,
	parameter int LOCK_HI_G10 = `GTPS_LOCK_HI_G10,
	parameter int LOCK_LO_G10 = `GTPS_LOCK_LO_G10,
	parameter int G10_PER_LSB = `GTPS_G10_PER_LSB
) (
	input  wire logic                clk,
	input  wire logic                nrst,
	input  wire logic                ce,
	input  wire logic [SAMPLE_W-1:0] sample,
	output var  logic                spd_out,
	output var  logic                sw_enabled,
	output var  logic                tracking_done,
	output var  logic [SAMPLE_W-1:0] peak_hold,
	output var  logic [SAMPLE_W-1:0] valley_hold
);

	// ======================================================================
	// Local sizing
	localparam int CNT_W  = $clog2(TRACK_CYCLES + 1);
	localparam int PROD_W = SAMPLE_W + 8;

	localparam logic [CNT_W-1:0]    TRACK_LAST = CNT_W'(TRACK_CYCLES - 1);
	localparam logic [PROD_W-1:0]   LOCK_HI    = PROD_W'(LOCK_HI_G10);
	localparam logic [PROD_W-1:0]   LOCK_LO    = PROD_W'(LOCK_LO_G10);
	localparam logic [PROD_W-1:0]   G10_LSB    = PROD_W'(G10_PER_LSB);

	// ======================================================================
	// Declarations
	gtps_pkg::gtps_state_t st;

	logic [CNT_W-1:0]    track_cnt;
	logic [SAMPLE_W-1:0] span;
	logic [SAMPLE_W-1:0] quarter;
	logic [SAMPLE_W:0]   slice_sum;
	logic [SAMPLE_W-1:0] slice_lvl;
	logic [PROD_W-1:0]   span_g10;
	logic                above_hi;
	logic                below_lo;
	logic                run_ok;
	logic                rise_evt;
	logic                fall_evt;

	// ======================================================================
	// Span, slicing level and preload step
	// Span clamps to zero so an empty start cannot wrap into a huge signal
	always_comb begin
		if (peak_hold > valley_hold) begin
			span = peak_hold - valley_hold;
		end else begin
			span = '0;
		end
	end

	// Preload taken from held counters only
	assign quarter   = span >> `GTPS_PRELOAD_SHIFT;
	// One extra bit keeps the sum exact before halving
	assign slice_sum = {1'b0, peak_hold} + {1'b0, valley_hold};
	assign slice_lvl = slice_sum[SAMPLE_W:1];

	// Compare in tenths of a gauss so no threshold is rounded
	assign span_g10 = PROD_W'(span) * G10_LSB;
	assign above_hi = span_g10 > LOCK_HI;
	assign below_lo = span_g10 < LOCK_LO;

	// Switching only in run state and not about to lock out
	assign run_ok   = ce && (st == gtps_pkg::ST_RUN) && !below_lo;
	// Output changes from the slicing comparison
	assign rise_evt = run_ok && !spd_out && (sample > slice_lvl);
	assign fall_evt = run_ok && spd_out && (sample < slice_lvl);

	// ======================================================================
	// Startup sequencer
	// Reset starts tracking with peak at zero, valley at full scale, output high; trackers then run for the settle time
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st <= gtps_pkg::ST_TRACK;
		end else if (ce) begin
			unique case (st)
				gtps_pkg::ST_TRACK: begin
					if (track_cnt == TRACK_LAST) begin
						st <= gtps_pkg::ST_LOCKED;
					end
				end
				gtps_pkg::ST_LOCKED: begin
					if (above_hi) begin
						st <= gtps_pkg::ST_RUN;
					end
				end
				gtps_pkg::ST_RUN: begin
					if (below_lo) begin
						st <= gtps_pkg::ST_LOCKED;
					end
				end
			endcase
		end
	end

	// Settle counter stops at its last value
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			track_cnt <= '0;
		end else if (ce && (st == gtps_pkg::ST_TRACK) && (track_cnt != TRACK_LAST)) begin
			track_cnt <= track_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tracking_done <= 1'b0;
			sw_enabled    <= 1'b0;
		end else if (ce) begin
			tracking_done <= tracking_done || ((st == gtps_pkg::ST_TRACK) && (track_cnt == TRACK_LAST));
			if (st == gtps_pkg::ST_LOCKED) begin
				sw_enabled <= above_hi;
			end else if (st == gtps_pkg::ST_RUN) begin
				sw_enabled <= !below_lo;
			end
		end
	end

	// ======================================================================
	// Peak tracker
	// Preload on a falling change takes priority over the step
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			peak_hold <= '0;
		end else if (ce) begin
			if (fall_evt) begin
				peak_hold <= peak_hold - quarter;
			end else if (sample > peak_hold) begin
				peak_hold <= peak_hold + 1'b1;
			end
		end
	end

	// ======================================================================
	// Valley tracker
	// Starts at full scale so the first samples pull it down
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			valley_hold <= '1;
		end else if (ce) begin
			if (rise_evt) begin
				valley_hold <= valley_hold + quarter;
			end else if (sample < valley_hold) begin
				valley_hold <= valley_hold - 1'b1;
			end
		end
	end

	// ======================================================================
	// Output stage
	// High under reset and whenever not running
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			spd_out <= 1'b1;
		end else if (ce) begin
			if (st != gtps_pkg::ST_RUN || below_lo) begin
				spd_out <= 1'b1;
			end else if (fall_evt) begin
				spd_out <= 1'b0;
			end else if (rise_evt) begin
				spd_out <= 1'b1;
			end
		end
	end

	// ======================================================================
	// Assertions
	AST_PEAK_STEP: assert property (
		@(posedge clk) disable iff (!nrst)
		(ce && !fall_evt && (sample > peak_hold)) |=> (peak_hold == $past(peak_hold) + 1'b1)
	) else $error("Peak did not step up by one");

	AST_PEAK_STOP: assert property (
		@(posedge clk) disable iff (!nrst)
		(ce && !fall_evt && (sample <= peak_hold)) |=> $stable(peak_hold)
	) else $error("Peak moved without a higher sample");

	AST_VALLEY_STEP: assert property (
		@(posedge clk) disable iff (!nrst)
		(ce && !rise_evt && (sample < valley_hold)) |=> (valley_hold == $past(valley_hold) - 1'b1)
	) else $error("Valley did not step down by one");

	AST_FALL_CHANGE: assert property (
		@(posedge clk) disable iff (!nrst)
		(ce && (st == gtps_pkg::ST_RUN) && !below_lo && spd_out
			&& (2 * sample < peak_hold + valley_hold - 1)) |=> !spd_out
	) else $error("Output did not fall below the slicing level");

	AST_RISE_PRELOAD: assert property (
		@(posedge clk) disable iff (!nrst)
		rise_evt |=> (valley_hold == $past(valley_hold) + (($past(peak_hold) - $past(valley_hold)) >> 2))
	) else $error("Valley preload wrong on rising change");

	AST_FALL_PRELOAD: assert property (
		@(posedge clk) disable iff (!nrst)
		fall_evt |=> (peak_hold == $past(peak_hold) - (($past(peak_hold) - $past(valley_hold)) >> 2))
	) else $error("Peak preload wrong on falling change");

	AST_HIGH_IN_LOCK: assert property (
		@(posedge clk) disable iff (!nrst)
		(ce && (st != gtps_pkg::ST_RUN)) |=> spd_out
	) else $error("Output not high outside run state");

	AST_LOCK_RELEASE: assert property (
		@(posedge clk) disable iff (!nrst)
		(ce && (st == gtps_pkg::ST_LOCKED) && (span * G10_PER_LSB > LOCK_HI_G10)) |=> (st == gtps_pkg::ST_RUN)
	) else $error("Lockout not released above upper level");

	AST_LOCK_ENTER: assert property (
		@(posedge clk) disable iff (!nrst)
		(ce && (st == gtps_pkg::ST_RUN) && (span * G10_PER_LSB < LOCK_LO_G10)) |=> (st == gtps_pkg::ST_LOCKED) && spd_out
	) else $error("Lockout not entered below lower level");

	AST_TRACK_END: assert property (
		@(posedge clk) disable iff (!nrst)
		(ce && (st == gtps_pkg::ST_TRACK) && (track_cnt == TRACK_LAST)) |=> (st == gtps_pkg::ST_LOCKED)
	) else $error("Tracking stage did not end on time");

	AST_STAGE_ORDER: assert property (
		@(posedge clk) disable iff (!nrst)
		(st == gtps_pkg::ST_TRACK) |=> (st != gtps_pkg::ST_RUN)
	) else $error("Run state reached before lockout stage");

	AST_FREEZE: assert property (
		@(posedge clk) disable iff (!nrst)
		!ce |=> $stable(peak_hold) && $stable(valley_hold) && $stable(spd_out) && $stable(st)
	) else $error("State moved while clock enable low");

	AST_VALLEY_STOP: assert property (
		@(posedge clk) disable iff (!nrst)
		(ce && !rise_evt && (sample >= valley_hold)) |=> $stable(valley_hold)
	) else $error("Valley moved without a lower sample");

	AST_RISE_CHANGE: assert property (
		@(posedge clk) disable iff (!nrst)
		(ce && (st == gtps_pkg::ST_RUN) && !below_lo && !spd_out
			&& (2 * sample > peak_hold + valley_hold + 1)) |=> spd_out
	) else $error("Output did not rise above the slicing level");

	AST_AT_SLICE: assert property (
		@(posedge clk) disable iff (!nrst)
		(ce && (st == gtps_pkg::ST_RUN) && !below_lo
			&& ((2 * sample == peak_hold + valley_hold) || (2 * sample + 1 == peak_hold + valley_hold)))
		|=> $stable(spd_out)
	) else $error("Output changed on a sample equal to the slicing level");

	AST_LOCK_NO_PRELOAD: assert property (
		@(posedge clk) disable iff (!nrst)
		(ce && ((st != gtps_pkg::ST_RUN) || below_lo))
			|=> (peak_hold >= $past(peak_hold)) && (valley_hold <= $past(valley_hold))
	) else $error("Preload applied while locked out");

	AST_SW_EN_STATE: assert property (
		@(posedge clk) disable iff (!nrst)
		sw_enabled == (st == gtps_pkg::ST_RUN)
	) else $error("Switching enable disagrees with run state");

	AST_DONE_STATE: assert property (
		@(posedge clk) disable iff (!nrst)
		tracking_done == (st != gtps_pkg::ST_TRACK)
	) else $error("Settle flag disagrees with startup stage");

	AST_TRACK_HOLD: assert property (
		@(posedge clk) disable iff (!nrst)
		(ce && (st == gtps_pkg::ST_TRACK) && (track_cnt != TRACK_LAST))
			|=> (st == gtps_pkg::ST_TRACK) && (track_cnt == $past(track_cnt) + 1'b1)
	) else $error("Tracking stage left early or count skipped");

	AST_LOW_ONLY_RUN: assert property (
		@(posedge clk) disable iff (!nrst)
		!spd_out |-> (st == gtps_pkg::ST_RUN) && sw_enabled
	) else $error("Output low outside run state");

endmodule : gtps_slicer

`default_nettype wire

// *** hdl/gtps_defines.svh ***
// Constants for the gear tooth peak and valley slicer
`ifndef GTPS_DEFINES_SVH
`define GTPS_DEFINES_SVH

// ==========================================================================
// Sample format
`define GTPS_SAMPLE_W          12

// ==========================================================================
// Timing
`define GTPS_CLK_PERIOD_PS     5000
`define GTPS_TRACK_TIME_US     1000
`define GTPS_TRACK_CYCLES      ((`GTPS_TRACK_TIME_US * 1000000) / `GTPS_CLK_PERIOD_PS)

// ==========================================================================
// Minimum signal lockout, tenths of a gauss
`define GTPS_LOCK_HI_G10       385
`define GTPS_LOCK_LO_G10       275
`define GTPS_G10_PER_LSB       10

// ==========================================================================
// Preload divisor as a right shift (divide by four)
`define GTPS_PRELOAD_SHIFT     2

`endif

// *** hdl/gtps_pkg.sv ***
// Types shared by the gear tooth peak and valley slicer
`default_nettype none
package gtps_pkg;

	// ======================================================================
	// Startup and run states
	typedef enum logic [1:0] {
		ST_TRACK,
		ST_LOCKED,
		ST_RUN
	} gtps_state_t;

endpackage : gtps_pkg

`default_nettype wire

// *** tb/gtps_host_model.sv ***
// Host side model that counts speed output edges
`timescale 1ns/100ps
`default_nettype none
module gtps_host_model (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic spd_out,
	output var  int   n_fall,
	output var  int   n_rise
);
	logic prev;
	// ==========================================================
	// Edge counting
	// Samples on the clock only, as a polling host would
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prev   <= 1'b1;
			n_fall <= 0;
			n_rise <= 0;
		end else begin
			prev <= spd_out;
			if (prev && !spd_out) n_fall <= n_fall + 1;
			if (!prev && spd_out) n_rise <= n_rise + 1;
		end
	end
endmodule : gtps_host_model
`default_nettype wire

// *** tb/gear_tooth_peak_valley_slicer_test.sv ***
// Self-checking bench for the peak and valley slicer
`timescale 1ns/100ps
`default_nettype none
module gear_tooth_peak_valley_slicer_test;
	// Short settle stage keeps the run brief
	localparam int TRK = 16;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        ce = 1'b1;
	logic [11:0] sample = 12'h900;
	logic        spd_out;
	logic        sw_enabled;
	logic        tracking_done;
	logic [11:0] peak_hold;
	logic [11:0] valley_hold;
	int          n_fall;
	int          n_rise;
	int          n_mismatch = 0;
	int          n_compared = 0;

	always #2.5 clk = ~clk;

	gtps_slicer #(.TRACK_CYCLES(TRK)) u_dut (.clk(clk), .nrst(nrst), .ce(ce), .sample(sample),
		.spd_out(spd_out), .sw_enabled(sw_enabled), .tracking_done(tracking_done),
		.peak_hold(peak_hold), .valley_hold(valley_hold));
	gtps_host_model u_host (.clk(clk), .nrst(nrst), .spd_out(spd_out), .n_fall(n_fall), .n_rise(n_rise));

	// ==========================================================
	// Helpers
	task automatic chk(input logic ok, input string msg);
		n_compared++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : chk

	// Always entered just after a rising edge
	task automatic tick(input logic [11:0] s, input int n);
		sample = s;
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : stop_test

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		nrst = 1'b0;
		repeat (16) @(posedge clk);
		#1;
		chk(spd_out === 1'b1 && sw_enabled === 1'b0, "reset outputs");
		chk(tracking_done === 1'b0 && peak_hold === 12'h000 && valley_hold === 12'hfff, "reset holds");
		nrst = 1'b1;
		$display("test reset done");
	endtask : t_reset

	task automatic t_track();
		tick(12'h900, 5);
		chk(peak_hold === 12'h005 && valley_hold === 12'hffa, "track step");
		tick(12'h900, TRK - 6);
		chk(tracking_done === 1'b0, "settle early");
		tick(12'h900, 1);
		chk(tracking_done === 1'b1 && sw_enabled === 1'b0 && spd_out === 1'b1, "settle end");
		ce = 1'b0;
		tick(12'h900, 4);
		chk(peak_hold === 12'h010 && valley_hold === 12'hfef, "freeze");
		ce = 1'b1;
		for (int i = 0; i < 3000 && peak_hold !== 12'h900; i++) tick(12'h900, 1);
		tick(12'h900, 3);
		chk(peak_hold === 12'h900 && valley_hold === 12'h900, "track stop");
		chk(sw_enabled === 1'b0 && spd_out === 1'b1, "small span locked");
		$display("test track done");
	endtask : t_track

	task automatic t_lockout();
		tick(12'hfff, 20);
		tick(12'h000, 1);
		chk(spd_out === 1'b1 && peak_hold === 12'h914 && valley_hold === 12'h8ff, "locked low");
		tick(12'hfff, 18);
		chk(peak_hold === 12'h926 && sw_enabled === 1'b0, "span 39 seen");
		tick(12'hfff, 1);
		chk(sw_enabled === 1'b1 && spd_out === 1'b1, "lockout release");
		$display("test lockout done");
	endtask : t_lockout

	task automatic t_slice();
		tick(12'hfff, 160);
		// Just under the slice: fall, peak preloaded from held span
		tick(12'h962, 1);
		chk(spd_out === 1'b0 && peak_hold === 12'h995 && valley_hold === 12'h8ff, "fall");
		tick(12'h94a, 1);
		chk(spd_out === 1'b0 && peak_hold === 12'h995 && valley_hold === 12'h8ff, "at slice");
		tick(12'h94b, 1);
		chk(spd_out === 1'b1 && peak_hold === 12'h995 && valley_hold === 12'h924, "rise");
		// Sample equal to the new slice lets the host see the rise
		tick(12'h95c, 1);
		chk(spd_out === 1'b1 && n_fall == 1 && n_rise == 1, "host edges");
		$display("test slice done");
	endtask : t_slice

	// Alternate crossings shrink the span by quarters until lockout
	task automatic t_relock();
		tick(12'h924, 1);
		chk(spd_out === 1'b0 && peak_hold === 12'h979 && valley_hold === 12'h924, "shrink fall");
		tick(12'h979, 1);
		chk(spd_out === 1'b1 && valley_hold === 12'h939, "shrink rise");
		tick(12'h939, 1);
		tick(12'h969, 1);
		tick(12'h945, 1);
		chk(peak_hold === 12'h960 && valley_hold === 12'h945, "span 27 held");
		chk(spd_out === 1'b0 && sw_enabled === 1'b1, "still running");
		tick(12'h960, 1);
		chk(spd_out === 1'b1 && sw_enabled === 1'b0, "lockout entered");
		chk(peak_hold === 12'h960 && valley_hold === 12'h945, "no preload on lockout");
		tick(12'h950, 1);
		chk(spd_out === 1'b1 && peak_hold === 12'h960, "no fall in lockout");
		chk(n_fall == 4 && n_rise == 4, "host relock edges");
		$display("test relock done");
	endtask : t_relock

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		t_reset();
		t_track();
		t_lockout();
		t_slice();
		t_relock();
		t_reset();
		stop_test();
	end

	initial begin
		#100000;
		n_mismatch++;
		stop_test();
	end
endmodule : gear_tooth_peak_valley_slicer_test
`default_nettype wire
